// ==== hdl/pcco_axil_slave.sv ====
// AXI4-Lite slave front end that turns bus writes into one-cycle register strobes
`timescale 1ns/10ps
module pcco_axil_slave (
	input  wire logic                       clk_sys,
	input  wire logic                       sys_rst,
	input  wire logic [pcco_pkg::ADDR_W-1:0] s_awaddr,
	input  wire logic                       s_awvalid,
	output logic                            s_awready,
	input  wire logic [31:0]                s_wdata,
	input  wire logic [3:0]                 s_wstrb,
	input  wire logic                       s_wvalid,
	output logic                            s_wready,
	output logic [1:0]                      s_bresp,
	output logic                            s_bvalid,
	input  wire logic                       s_bready,
	input  wire logic [pcco_pkg::ADDR_W-1:0] s_araddr,
	input  wire logic                       s_arvalid,
	output logic                            s_arready,
	output logic [31:0]                     s_rdata,
	output logic [1:0]                      s_rresp,
	output logic                            s_rvalid,
	input  wire logic                       s_rready,
	output logic                            wr_strobe,
	output logic [pcco_pkg::ADDR_W-1:0]     wr_addr,
	output logic [31:0]                     wr_data,
	output logic [3:0]                      wr_strb,
	input  wire logic                       wr_hit,
	input  wire logic [pcco_pkg::ADDR_W-1:0] rd_addr_q,
	output logic [pcco_pkg::ADDR_W-1:0]     rd_addr,
	input  wire logic [31:0]                rd_word,
	input  wire logic                       rd_hit
);
	logic                        aw_held_reg;
	logic                        w_held_reg;
	logic [pcco_pkg::ADDR_W-1:0] awaddr_reg;
	logic [31:0]                 wdata_reg;
	logic [3:0]                  wstrb_reg;

	// Address and data may land in either order; each is held until its partner arrives
	assign s_awready = !aw_held_reg && !s_bvalid;
	assign s_wready  = !w_held_reg && !s_bvalid;
	assign s_arready = !s_rvalid;
	assign wr_strobe = aw_held_reg && w_held_reg;
	assign wr_addr   = awaddr_reg;
	assign wr_data   = wdata_reg;
	assign wr_strb   = wstrb_reg;
	assign rd_addr   = s_araddr;

	// Write capture; strobe fires in the same cycle that both halves are held
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			awaddr_reg  <= '0;
			wdata_reg   <= pcco_pkg::ZERO_WORD;
			wstrb_reg   <= 4'h0;
		end else if (wr_strobe) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_held_reg <= 1'b1;
				awaddr_reg  <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg  <= s_wdata;
				wstrb_reg  <= s_wstrb;
			end
		end
	end

	// Write response raised the cycle after the strobe, held until the master takes it
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_bvalid <= 1'b0;
			s_bresp  <= pcco_pkg::RESP_OKAY;
		end else if (wr_strobe) begin
			s_bvalid <= 1'b1;
			s_bresp  <= wr_hit ? pcco_pkg::RESP_OKAY : pcco_pkg::RESP_SLVERR;
		end else if (s_bready) begin
			s_bvalid <= 1'b0;
		end
	end

	// Read data registered one cycle after the address is taken
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_rvalid <= 1'b0;
			s_rdata  <= pcco_pkg::ZERO_WORD;
			s_rresp  <= pcco_pkg::RESP_OKAY;
		end else if (s_arvalid && s_arready) begin
			s_rvalid <= 1'b1;
			s_rdata  <= rd_hit ? rd_word : pcco_pkg::ZERO_WORD;
			s_rresp  <= rd_hit ? pcco_pkg::RESP_OKAY : pcco_pkg::RESP_SLVERR;
		end else if (s_rready) begin
			s_rvalid <= 1'b0;
		end
	end

	logic unused_q;
	assign unused_q = ^rd_addr_q;
endmodule

// ==== hdl/pcco_cop_seq.sv ====
// Compute-operation entry and exit sequencer that produces the acknowledge status
`timescale 1ns/10ps
module pcco_cop_seq (
	input  wire logic                     clk_sys,
	input  wire logic                     sys_rst,
	input  wire logic                     request,
	output logic                          cop_enter_req,
	input  wire logic                     cop_enter_done,
	output logic                          cop_exit_req,
	input  wire logic                     cop_exit_done,
	output logic                          acknowledge,
	output pcco_pkg::pcco_cop_state_t     state
);
	pcco_pkg::pcco_cop_state_t state_reg;
	pcco_pkg::pcco_cop_state_t state_next;

	// Entry must finish before exit starts, so a short request still sees a full round trip
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			pcco_pkg::PCCO_IDLE:   if (request) state_next = pcco_pkg::PCCO_ENTER;
			pcco_pkg::PCCO_ENTER:  if (cop_enter_done) state_next = pcco_pkg::PCCO_ACTIVE;
			pcco_pkg::PCCO_ACTIVE: if (!request) state_next = pcco_pkg::PCCO_EXIT;
			pcco_pkg::PCCO_EXIT:   if (cop_exit_done) state_next = pcco_pkg::PCCO_IDLE;
			default:               state_next = pcco_pkg::PCCO_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_reg <= pcco_pkg::PCCO_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Ack high from completed entry until completed exit
	assign acknowledge   = (state_reg == pcco_pkg::PCCO_ACTIVE) || (state_reg == pcco_pkg::PCCO_EXIT);
	assign cop_enter_req = (state_reg == pcco_pkg::PCCO_ENTER);
	assign cop_exit_req  = (state_reg == pcco_pkg::PCCO_EXIT);
	assign state         = state_reg;
endmodule

// ==== hdl/pcco_pkg.sv ====
// Package with register map, field layout and types for the platform control and compute-op bank
// Behaviour
// - The whole flash cache is off while the cache-off field holds 1 and on while it holds 0.
// - The cache-off field sits at bit 13 of the platform control register.
// - Bit 12 set to 1 stops instruction caching; 0 keeps it enabled.
// - Bit 11 set to 1 stops data caching; 0 keeps it enabled.
// - Writing 1 to bit 10 invalidates the whole flash cache.
// - The invalidate bit clears itself, always reads 0, and a written 0 does nothing.
// - Bit 9 at 0 selects fixed-priority crossbar arbitration, at 1 round-robin.
// - Bits 8 to 0 of platform control and bits 31 to 3 of compute-op control are read-only zero.
// - With wake-on-vector-fetch (bit 2) at 1 any vector fetch clears the request; at 0 it has no effect.
// - The acknowledge bit (bit 1) reads 1 from completed entry until completed exit, else 0.
// - Software requests a compute operation by setting bit 0 and ends it by clearing it; the device acts on it.
package pcco_pkg;
	localparam int          ADDR_W           = 4;
	localparam int          DATA_W           = 32;
	localparam logic [3:0]  OFF_PLATFORM     = 4'h0;
	localparam logic [3:0]  OFF_COMPUTE_OP   = 4'h4;
	localparam int          BIT_CACHE_OFF    = 13;
	localparam int          BIT_INSTR_OFF    = 12;
	localparam int          BIT_DATA_OFF     = 11;
	localparam int          BIT_INVALIDATE   = 10;
	localparam int          BIT_PRIORITY     = 9;
	localparam int          BIT_WAKE         = 2;
	localparam int          BIT_ACK          = 1;
	localparam int          BIT_REQ          = 0;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;
	localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;

	// Settings the platform control register drives into the flash and crossbar
	typedef struct packed {
		logic cache_off;
		logic instr_caching_off;
		logic data_caching_off;
		logic round_robin;
	} pcco_plat_t;

	// Compute-op handshake toward the power sequencer
	typedef struct packed {
		logic request;
		logic wake_on_vector_fetch;
	} pcco_cop_t;

	typedef enum logic [1:0] {
		PCCO_IDLE    = 2'b00,
		PCCO_ENTER   = 2'b01,
		PCCO_ACTIVE  = 2'b11,
		PCCO_EXIT    = 2'b10
	} pcco_cop_state_t;
endpackage

// ==== hdl/pcco_regs.sv ====
// Top of the platform control and compute-operation register bank
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module pcco_regs (
	input  wire logic                       clk_sys,
	input  wire logic                       sys_rst,
	input  wire logic [pcco_pkg::ADDR_W-1:0] s_awaddr,
	input  wire logic                       s_awvalid,
	output logic                            s_awready,
	input  wire logic [31:0]                s_wdata,
	input  wire logic [3:0]                 s_wstrb,
	input  wire logic                       s_wvalid,
	output logic                            s_wready,
	output logic [1:0]                      s_bresp,
	output logic                            s_bvalid,
	input  wire logic                       s_bready,
	input  wire logic [pcco_pkg::ADDR_W-1:0] s_araddr,
	input  wire logic                       s_arvalid,
	output logic                            s_arready,
	output logic [31:0]                     s_rdata,
	output logic [1:0]                      s_rresp,
	output logic                            s_rvalid,
	input  wire logic                       s_rready,
	output pcco_pkg::pcco_plat_t            plat_cfg,
	output logic                            flash_cache_invalidate,
	input  wire logic                       vector_fetch,
	output logic                            cop_enter_req,
	input  wire logic                       cop_enter_done,
	output logic                            cop_exit_req,
	input  wire logic                       cop_exit_done,
	output pcco_pkg::pcco_cop_t             cop_ctrl
);
	logic                        wr_strobe;
	logic [pcco_pkg::ADDR_W-1:0] wr_addr;
	logic [31:0]                 wr_data;
	logic [3:0]                  wr_strb;
	logic                        wr_hit;
	logic [pcco_pkg::ADDR_W-1:0] rd_addr;
	logic [31:0]                 rd_word;
	logic                        rd_hit;
	logic                        flash_cache_off_reg;
	logic                        flash_instr_caching_off_reg;
	logic                        flash_data_caching_off_reg;
	logic                        master_priority_scheme_reg;
	logic                        invalidate_reg;
	logic                        wake_on_vector_fetch_reg;
	logic                        compute_op_request_reg;
	logic                        compute_op_acknowledge;
	logic                        wr_plat;
	logic                        wr_cop;
	logic                        lane1;

	// Decode an address against one register offset
	function automatic logic hit(input logic [pcco_pkg::ADDR_W-1:0] a, input logic [3:0] off);
		hit = (a == off);
	endfunction

	pcco_axil_slave u_bus (
		.clk_sys   (clk_sys),
		.sys_rst   (sys_rst),
		.s_awaddr  (s_awaddr),
		.s_awvalid (s_awvalid),
		.s_awready (s_awready),
		.s_wdata   (s_wdata),
		.s_wstrb   (s_wstrb),
		.s_wvalid  (s_wvalid),
		.s_wready  (s_wready),
		.s_bresp   (s_bresp),
		.s_bvalid  (s_bvalid),
		.s_bready  (s_bready),
		.s_araddr  (s_araddr),
		.s_arvalid (s_arvalid),
		.s_arready (s_arready),
		.s_rdata   (s_rdata),
		.s_rresp   (s_rresp),
		.s_rvalid  (s_rvalid),
		.s_rready  (s_rready),
		.wr_strobe (wr_strobe),
		.wr_addr   (wr_addr),
		.wr_data   (wr_data),
		.wr_strb   (wr_strb),
		.wr_hit    (wr_hit),
		.rd_addr_q (wr_addr),
		.rd_addr   (rd_addr),
		.rd_word   (rd_word),
		.rd_hit    (rd_hit)
	);

	pcco_cop_seq u_seq (
		.clk_sys        (clk_sys),
		.sys_rst        (sys_rst),
		.request        (compute_op_request_reg),
		.cop_enter_req  (cop_enter_req),
		.cop_enter_done (cop_enter_done),
		.cop_exit_req   (cop_exit_req),
		.cop_exit_done  (cop_exit_done),
		.acknowledge    (compute_op_acknowledge),
		.state          ()
	);

	// Write decode; all control bits live in lanes 0 and 1
	assign wr_plat = wr_strobe && hit(wr_addr, pcco_pkg::OFF_PLATFORM);
	assign wr_cop  = wr_strobe && hit(wr_addr, pcco_pkg::OFF_COMPUTE_OP);
	assign wr_hit  = hit(wr_addr, pcco_pkg::OFF_PLATFORM) || hit(wr_addr, pcco_pkg::OFF_COMPUTE_OP);
	assign lane1   = wr_strb[1];

	// Platform control storage
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			flash_cache_off_reg         <= 1'b0;
			flash_instr_caching_off_reg <= 1'b0;
			flash_data_caching_off_reg  <= 1'b0;
			master_priority_scheme_reg  <= 1'b0;
		end else if (wr_plat && lane1) begin
			flash_cache_off_reg         <= wr_data[pcco_pkg::BIT_CACHE_OFF];
			flash_instr_caching_off_reg <= wr_data[pcco_pkg::BIT_INSTR_OFF];
			flash_data_caching_off_reg  <= wr_data[pcco_pkg::BIT_DATA_OFF];
			master_priority_scheme_reg  <= wr_data[pcco_pkg::BIT_PRIORITY];
		end
	end

	// One-cycle invalidate pulse; a written 0 leaves nothing behind
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			invalidate_reg <= 1'b0;
		end else begin
			invalidate_reg <= wr_plat && lane1 && wr_data[pcco_pkg::BIT_INVALIDATE];
		end
	end

	// Wake-on-vector-fetch option
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wake_on_vector_fetch_reg <= 1'b0;
		end else if (wr_cop && wr_strb[0]) begin
			wake_on_vector_fetch_reg <= wr_data[pcco_pkg::BIT_WAKE];
		end
	end

	// Request bit; a vector fetch in the same cycle as a setting write wins, so the wake is not lost
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			compute_op_request_reg <= 1'b0;
		end else if (vector_fetch && wake_on_vector_fetch_reg) begin
			compute_op_request_reg <= 1'b0;
		end else if (wr_cop && wr_strb[0]) begin
			compute_op_request_reg <= wr_data[pcco_pkg::BIT_REQ];
		end
	end

	// Read mux; reserved and invalidate bits fall out as zero, ack comes from the sequencer only
	always_comb begin
		rd_word = pcco_pkg::ZERO_WORD;
		rd_hit  = 1'b1;
		if (hit(rd_addr, pcco_pkg::OFF_PLATFORM)) begin
			rd_word[pcco_pkg::BIT_CACHE_OFF] = flash_cache_off_reg;
			rd_word[pcco_pkg::BIT_INSTR_OFF] = flash_instr_caching_off_reg;
			rd_word[pcco_pkg::BIT_DATA_OFF]  = flash_data_caching_off_reg;
			rd_word[pcco_pkg::BIT_PRIORITY]  = master_priority_scheme_reg;
		end else if (hit(rd_addr, pcco_pkg::OFF_COMPUTE_OP)) begin
			rd_word[pcco_pkg::BIT_WAKE] = wake_on_vector_fetch_reg;
			rd_word[pcco_pkg::BIT_ACK]  = compute_op_acknowledge;
			rd_word[pcco_pkg::BIT_REQ]  = compute_op_request_reg;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// Cache-off overrides both per-type bits
	assign plat_cfg.cache_off         = flash_cache_off_reg;
	assign plat_cfg.instr_caching_off = flash_cache_off_reg | flash_instr_caching_off_reg;
	assign plat_cfg.data_caching_off  = flash_cache_off_reg | flash_data_caching_off_reg;
	assign plat_cfg.round_robin       = master_priority_scheme_reg;
	assign flash_cache_invalidate     = invalidate_reg;
	assign cop_ctrl.request           = compute_op_request_reg;
	assign cop_ctrl.wake_on_vector_fetch = wake_on_vector_fetch_reg;
endmodule

// ==== tb/pcco_regs_properties.sv ====
// Concurrent checks on the register bank ports
`timescale 1ns/10ps
module pcco_regs_properties (
	input wire logic                 clk_sys,
	input wire logic                 sys_rst,
	input wire logic                 s_arready,
	input wire logic                 s_arvalid,
	input wire logic                 s_bvalid,
	input wire logic                 s_bready,
	input wire logic                 s_rvalid,
	input wire logic                 s_rready,
	input wire logic [31:0]          s_rdata,
	input wire pcco_pkg::pcco_plat_t plat_cfg,
	input wire logic                 flash_cache_invalidate,
	input wire logic                 vector_fetch,
	input wire logic                 cop_enter_req,
	input wire logic                 cop_enter_done,
	input wire logic                 cop_exit_req,
	input wire pcco_pkg::pcco_cop_t  cop_ctrl
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// Cache off must shut both access types, whatever the per-type bits hold
	property p_cache_all; plat_cfg.cache_off |-> plat_cfg.instr_caching_off && plat_cfg.data_caching_off; endproperty
	a_cache_all: assert property (p_cache_all) else $error("cache off left a type on");
	property p_inv_one; flash_cache_invalidate |=> !flash_cache_invalidate; endproperty
	a_inv_one: assert property (p_inv_one) else $error("invalidate longer than one cycle");
	// Upper bits and the invalidate bit read zero in both words
	property p_rsvd; s_rvalid |-> s_rdata[31:14] == 18'h0 && !s_rdata[10] && s_rdata[8:3] == 6'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("nonzero reserved read bits");
	property p_wake; vector_fetch && cop_ctrl.wake_on_vector_fetch |=> !cop_ctrl.request; endproperty
	a_wake: assert property (p_wake) else $error("vector fetch kept the request");
	// Judged on the cycle before the move, since a write or fetch may change the request on the same edge
	property p_enter; $rose(cop_enter_req) |-> $past(cop_ctrl.request); endproperty
	a_enter: assert property (p_enter) else $error("entry without request");
	property p_exit; $rose(cop_exit_req) |-> !$past(cop_ctrl.request); endproperty
	a_exit: assert property (p_exit) else $error("exit while requested");
	property p_enter_hold; cop_enter_req && !cop_enter_done |=> cop_enter_req; endproperty
	a_enter_hold: assert property (p_enter_hold) else $error("entry dropped before done");
	// Responses stand until taken; no new read while one is pending
	property p_bhold; s_bvalid && !s_bready |=> s_bvalid; endproperty
	a_bhold: assert property (p_bhold) else $error("write response withdrawn");
	property p_rhold; s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read response changed");
	property p_ar_busy; s_rvalid |-> !s_arready; endproperty
	a_ar_busy: assert property (p_ar_busy) else $error("read taken while busy");
	property p_ar_answer; s_arvalid && s_arready |=> s_rvalid; endproperty
	a_ar_answer: assert property (p_ar_answer) else $error("read address taken without answer");
	c_inv: cover property (flash_cache_invalidate);
	c_enter: cover property ($rose(cop_enter_req));
	c_exit: cover property ($rose(cop_exit_req));
	c_wake: cover property (vector_fetch && cop_ctrl.wake_on_vector_fetch && cop_ctrl.request);
endmodule

bind pcco_regs pcco_regs_properties u_props (.clk_sys(clk_sys), .sys_rst(sys_rst), .s_arready(s_arready),
	.s_bvalid(s_bvalid), .s_bready(s_bready), .s_rvalid(s_rvalid), .s_rready(s_rready), .s_rdata(s_rdata),
	.plat_cfg(plat_cfg), .flash_cache_invalidate(flash_cache_invalidate), .vector_fetch(vector_fetch),
	.cop_enter_req(cop_enter_req), .cop_enter_done(cop_enter_done), .cop_exit_req(cop_exit_req),
	.cop_ctrl(cop_ctrl), .s_arvalid(s_arvalid));

// ==== tb/testbench.sv ====
// Self-checking bench for the platform control and compute-op register bank
`timescale 1ns/10ps
module testbench;
	logic                        clk_sys, sys_rst, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic                        s_arvalid, s_arready, s_rvalid, s_rready, flash_cache_invalidate, vector_fetch;
	logic                        cop_enter_req, cop_enter_done, cop_exit_req, cop_exit_done;
	logic [pcco_pkg::ADDR_W-1:0] s_awaddr, s_araddr;
	logic [3:0]                  s_wstrb;
	logic [31:0]                 s_wdata, s_rdata;
	logic [1:0]                  s_bresp, s_rresp;
	pcco_pkg::pcco_plat_t        plat_cfg;
	pcco_pkg::pcco_cop_t         cop_ctrl;
	int                          fail_count, n_checks, cyc, inv_cnt;
	localparam logic [3:0] PL = pcco_pkg::OFF_PLATFORM;
	localparam logic [3:0] CO = pcco_pkg::OFF_COMPUTE_OP;
	localparam logic [1:0] OK = pcco_pkg::RESP_OKAY;

	pcco_regs dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
		.s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
		.s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
		.s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
		.plat_cfg(plat_cfg), .flash_cache_invalidate(flash_cache_invalidate), .vector_fetch(vector_fetch),
		.cop_enter_req(cop_enter_req), .cop_enter_done(cop_enter_done), .cop_exit_req(cop_exit_req),
		.cop_exit_done(cop_exit_done), .cop_ctrl(cop_ctrl));

	always #4 clk_sys = ~clk_sys;

	// Cycle ceiling and invalidate pulse counter
	always @(posedge clk_sys) begin
		cyc++;
		if (flash_cache_invalidate === 1'h1) inv_cnt++;
		if (cyc == 4000) begin
			fail_count++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Handshakes are judged at the falling edge, acted on at the next rising edge
	task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] st, input logic [1:0] er);
		logic ha, hw, hb;
		logic [1:0] r;
		r = 2'h3;
		@(posedge clk_sys);
		s_awaddr <= a;
		s_wdata <= d;
		s_wstrb <= st;
		s_awvalid <= 1'h1;
		s_wvalid <= 1'h1;
		s_bready <= 1'h1;
		for (int t = 0; t < 40; t++) begin
			@(negedge clk_sys);
			ha = s_awvalid & s_awready;
			hw = s_wvalid & s_wready;
			hb = s_bvalid & s_bready;
			if (hb) r = s_bresp;
			@(posedge clk_sys);
			if (ha) s_awvalid <= 1'h0;
			if (hw) s_wvalid <= 1'h0;
			if (hb) begin
				s_bready <= 1'h0;
				break;
			end
		end
		chk("bresp", {30'h0, r}, {30'h0, er});
	endtask

	task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic ha, hr;
		logic [31:0] d;
		logic [1:0] r;
		d = 32'hDEAD_BEEF;
		r = 2'h3;
		@(posedge clk_sys);
		s_araddr <= a;
		s_arvalid <= 1'h1;
		s_rready <= 1'h1;
		for (int t = 0; t < 40; t++) begin
			@(negedge clk_sys);
			ha = s_arvalid & s_arready;
			hr = s_rvalid & s_rready;
			if (hr) d = s_rdata;
			if (hr) r = s_rresp;
			@(posedge clk_sys);
			if (ha) s_arvalid <= 1'h0;
			if (hr) begin
				s_rready <= 1'h0;
				break;
			end
		end
		chk(nm, d, exp);
		chk("rresp", {30'h0, r}, {30'h0, er});
	endtask

	// Waits a bounded time for the entry (0) or exit (1) request
	task automatic wreq(input bit ex);
		logic s;
		for (int t = 0; t < 20; t++) begin
			@(negedge clk_sys);
			s = ex ? cop_exit_req : cop_enter_req;
			if (s === 1'h1) break;
		end
		chk(ex ? "exit_req" : "enter_req", {31'h0, s}, 32'h1);
	endtask

	// One-cycle pulse: 0 entry done, 1 exit done, 2 vector fetch
	task automatic pulse(input int k);
		@(posedge clk_sys);
		if (k == 0) cop_enter_done <= 1'h1;
		else if (k == 1) cop_exit_done <= 1'h1;
		else vector_fetch <= 1'h1;
		@(posedge clk_sys);
		cop_enter_done <= 1'h0;
		cop_exit_done <= 1'h0;
		vector_fetch <= 1'h0;
	endtask

	task automatic t_plat();
		logic [31:0] wd [7] = '{32'h2000, 32'h1000, 32'h0800, 32'h0200, 32'hFFFF_FFFF, 32'h0, 32'h2400};
		logic [31:0] rd [7] = '{32'h2000, 32'h1000, 32'h0800, 32'h0200, 32'h3A00, 32'h0, 32'h0};
		logic [3:0] st [7] = '{4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'h1};
		logic [3:0] cf [7] = '{4'hE, 4'h4, 4'h2, 4'h1, 4'hF, 4'h0, 4'h0};
		for (int i = 0; i < 7; i++) begin
			inv_cnt = 0;
			axw(PL, wd[i], st[i], OK);
			rchk("platform", PL, rd[i], OK);
			chk("plat_cfg", {28'h0, plat_cfg}, {28'h0, cf[i]});
			chk("invalidate", inv_cnt, (i == 4) ? 32'h1 : 32'h0);
		end
	endtask

	task automatic t_cop();
		axw(CO, 32'h3, 4'hF, OK);
		rchk("cop", CO, 32'h1, OK);
		wreq(0);
		pulse(0);
		rchk("cop", CO, 32'h3, OK);
		axw(CO, 32'h1, 4'hF, OK);
		rchk("cop", CO, 32'h3, OK);
		axw(CO, 32'h0, 4'hF, OK);
		wreq(1);
		rchk("cop", CO, 32'h2, OK);
		pulse(1);
		rchk("cop", CO, 32'h0, OK);
	endtask

	// Vector fetch ends an active request only while wake is set
	task automatic t_wake(input logic [31:0] w, input logic [31:0] e1, input logic [31:0] e2);
		axw(CO, w, 4'hF, OK);
		wreq(0);
		pulse(0);
		pulse(2);
		rchk("cop", CO, e1, OK);
		chk("cop_ctrl", {30'h0, cop_ctrl}, {30'h0, e1[0], e1[2]});
		axw(CO, w & 32'h4, 4'hF, OK);
		wreq(1);
		pulse(1);
		rchk("cop", CO, e2, OK);
	endtask

	initial begin
		{clk_sys, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, vector_fetch} = 7'h0;
		{cop_enter_done, cop_exit_done, s_awaddr, s_araddr, s_wstrb, s_wdata} = 46'h0;
		{fail_count, n_checks, cyc, inv_cnt} = 128'h0;
		sys_rst = 1'h1;
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'h0;
		rchk("platform", PL, 32'h0, OK);
		rchk("cop", CO, 32'h0, OK);
		t_plat();
		axw(4'h8, 32'hFFFF_FFFF, 4'hF, pcco_pkg::RESP_SLVERR);
		rchk("unmapped", 4'h8, 32'h0, pcco_pkg::RESP_SLVERR);
		axw(CO, 32'hFFFF_FFF8, 4'hF, OK);
		rchk("cop", CO, 32'h0, OK);
		t_cop();
		t_wake(32'h5, 32'h6, 32'h4);
		t_wake(32'h1, 32'h3, 32'h0);
		complete_run();
	end
endmodule
